// File: logic/fpc_device.sv
`timescale 1ns/100ps
`default_nettype none
module fpc_device
  import fpc_pkg::*;
#(
  parameter int RATIO = FPC_RATIO,
  parameter int WORDS = FPC_WORDS
) (
  // ****************************************
  // system
  // ****************************************
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  // link
  fpc_if.dev               link,
  // user side: configuration words out
  output logic             o_word_valid,
  output logic [31:0]      o_word,
  input  wire logic        i_word_ready,
  // init clock choice
  input  wire logic [1:0]  i_init_src,
  input  wire logic        i_init_done_en,
  input  wire logic        i_user_clk_tick,
  input  wire logic        i_osc_tick,
  output logic             o_user_mode
);
  typedef enum {POR, CLEAR, LOAD, FLUSH, POST, INIT, USER} fpc_state_t;
  fpc_state_t  st;
  logic        rq_s1;
  logic        rq_s2;
  logic        rq_d;
  logic        ck_s1;
  logic        ck_s2;
  logic        ck_d;
  logic [31:0] d_s1;
  logic [31:0] d_s2;
  logic [15:0] cnt;
  logic [7:0]  phase;
  logic [15:0] words;
  logic [1:0]  falls;
  logic        f_valid;
  logic        f_ready;
  logic [31:0] f_data;
  logic        rise;
  logic        fall;
  logic        init_tick;

  // ****************************************
  // synchronisers
  // ****************************************
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      rq_s1 <= 1'b1;
      rq_s2 <= 1'b1;
      rq_d  <= 1'b1;
      ck_s1 <= 1'b0;
      ck_s2 <= 1'b0;
      ck_d  <= 1'b0;
      d_s1  <= '0;
      d_s2  <= '0;
    end else begin
      rq_s1 <= link.cfg_request_n;
      rq_s2 <= rq_s1;
      rq_d  <= rq_s2;
      ck_s1 <= link.cfg_data_clock;
      ck_s2 <= ck_s1;
      ck_d  <= ck_s2;
      d_s1  <= link.data;
      d_s2  <= d_s1;
    end
  end
  // link clock edges as seen behind the synchroniser
  assign rise = ck_s2 && !ck_d;
  assign fall = !ck_s2 && ck_d;
  always_comb begin
    case (i_init_src)
      FPC_INIT_OSC:  init_tick = i_osc_tick;
      FPC_INIT_USER: init_tick = i_user_clk_tick;
      FPC_INIT_CFG_DATA_CLOCK: init_tick = fall;
      default:       init_tick = i_osc_tick;
    endcase
  end

  // ****************************************
  // sequence
  // ****************************************
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      st      <= POR;
      cnt     <= '0;
      phase   <= '0;
      words   <= '0;
      falls   <= '0;
      f_valid <= 1'b0;
      f_data  <= '0;
    end else begin
      // a word taken by the buffer leaves the holding stage
      if (f_valid && f_ready) begin
        f_valid <= 1'b0;
      end
      case (st)
        POR: begin
          cnt <= cnt + 1'b1;
          if (cnt == 16'(FPC_POR_CYC - 1)) begin
            st  <= CLEAR;
            cnt <= '0;
          end
        end
        CLEAR: begin
          phase <= '0;
          words <= '0;
          falls <= '0;
          if (rq_s2) begin
            st <= LOAD;
          end
        end
        LOAD: begin
          if (!rq_s2) begin
            st <= CLEAR;
          end else if (rise && f_ready) begin
            if (phase == 8'(RATIO - 1)) begin
              phase   <= '0;
              f_valid <= 1'b1;
              f_data  <= d_s2;
              words   <= words + 1'b1;
              if (words == 16'(WORDS - 1)) begin
                st <= FLUSH;
              end
            end else begin
              phase <= phase + 1'b1;
            end
          end
        end
        FLUSH: begin
          if (!f_valid) begin
            st <= POST;
          end
        end
        POST: begin
          if (!rq_s2) begin
            st <= CLEAR;
          end else if (fall) begin
            falls <= falls + 1'b1;
            if (falls == 2'd1) begin
              st  <= INIT;
              cnt <= '0;
            end
          end
        end
        INIT: begin
          if (!rq_s2) begin
            st <= CLEAR;
          end else if (init_tick) begin
            cnt <= cnt + 1'b1;
            if (cnt == 16'(FPC_INIT_CYC - 1)) begin
              st <= USER;
            end
          end
        end
        // the link clock is not looked at once configured
        USER: begin
          if (rq_d && !rq_s2) begin
            st <= CLEAR;
          end
        end
        default: begin
          st <= POR;
        end
      endcase
    end
  end

  // words wait here until the user side takes them
  fpc_fifo #(.WIDTH(32), .DEPTH(FPC_FIFO_DEPTH)) fpc_fifo_i (
    .i_mclk    (i_mclk),
    .i_rst_n   (i_rst_n),
    .i_wr_valid(f_valid),
    .i_wr_data (f_data),
    .o_wr_ready(f_ready),
    .o_rd_valid(o_word_valid),
    .o_rd_data (o_word),
    .i_rd_ready(i_word_ready)
  );

  // ****************************************
  // pins
  // ****************************************
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      link.status_o           <= 1'b0;
      link.status_oe          <= 1'b1;
      link.config_complete_o  <= 1'b0;
      link.config_complete_oe <= 1'b1;
      link.init_done_o        <= 1'b0;
      link.init_done_oe       <= 1'b0;
      o_user_mode             <= 1'b0;
    end else begin
      link.status_o           <= 1'b0;
      link.status_oe          <= (st == POR) || (st == CLEAR);
      link.config_complete_o  <= 1'b0;
      link.config_complete_oe <= (st == POR) || (st == CLEAR) || (st == LOAD) || (st == FLUSH);
      // init-done is pulled low only once the option has been loaded
      link.init_done_o        <= 1'b0;
      link.init_done_oe       <= i_init_done_en && ((st == POST) || (st == INIT));
      o_user_mode             <= (st == USER);
    end
  end
endmodule
`default_nettype wire

// File: logic/fpc_pkg.sv
// Operation
// - config request falling in user mode restarts
// - user mode: request, status, complete high
// - status held low for power-on delay
// - complete low before and during transfer
// - in user mode, config clock ignored
// - host drives config clock after completion
// - each word spans r config clocks
// - host pauses by holding clock low
// - data valid before first resumed rising edge
// - host sends the whole bitstream
// - complete released only after all data
// - two falling edges after complete start initialization
// - init-done low, then signals initialization end
// - init clock: oscillator, user clock, config clock
package fpc_pkg;
  // ****************************************
  // constants
  // ****************************************
  localparam int FPC_DATA_W       = 32;
  localparam int FPC_RATIO        = 2;
  localparam int FPC_WORDS        = 16;
  localparam int FPC_POR_NS       = 2000;
  localparam int FPC_CLK_NS       = 20;
  localparam int FPC_POR_CYC      = (FPC_POR_NS + FPC_CLK_NS - 1) / FPC_CLK_NS;
  localparam int FPC_CFG_LOW_NS   = 2000;
  localparam int FPC_CFG_LOW_CYC  = (FPC_CFG_LOW_NS + FPC_CLK_NS - 1) / FPC_CLK_NS;
  localparam int FPC_DIV          = 4;
  localparam int FPC_INIT_CYC     = 64;
  localparam int FPC_FIFO_DEPTH   = 4;
  localparam logic [1:0] FPC_INIT_OSC  = 2'h0;
  localparam logic [1:0] FPC_INIT_USER = 2'h1;
  localparam logic [1:0] FPC_INIT_CFG_DATA_CLOCK = 2'h2;
endpackage

// File: logic/fpc_if.sv
`timescale 1ns/100ps
`default_nettype none
interface fpc_if;
  logic        cfg_request_n;
  logic        status_o;
  logic        status_oe;
  logic        status_n;
  logic        config_complete_o;
  logic        config_complete_oe;
  logic        config_complete;
  logic        cfg_data_clock;
  logic [31:0] data;
  logic        init_done_o;
  logic        init_done_oe;
  logic        init_done;
  // open-drain wires pulled up
  assign status_n        = status_oe ? status_o : 1'b1;
  assign config_complete = config_complete_oe ? config_complete_o : 1'b1;
  assign init_done       = init_done_oe ? init_done_o : 1'b1;
  modport dev (input cfg_request_n, cfg_data_clock, data, status_n, config_complete,
               output status_o, status_oe, config_complete_o, config_complete_oe, init_done_o, init_done_oe);
  modport host (input status_n, config_complete, init_done,
                output cfg_request_n, cfg_data_clock, data);
endinterface
`default_nettype wire

// File: logic/fpc_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module fpc_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input  wire logic             i_mclk,
  input  wire logic             i_rst_n,
  input  wire logic             i_wr_valid,
  input  wire logic [WIDTH-1:0] i_wr_data,
  output logic                  o_wr_ready,
  output logic                  o_rd_valid,
  output logic [WIDTH-1:0]      o_rd_data,
  input  wire logic             i_rd_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp;
  logic [AW-1:0]    rp;
  logic [AW:0]      cnt;
  logic             wr;
  logic             rd;
  assign o_wr_ready = (cnt != (AW+1)'(DEPTH));
  assign o_rd_valid = (cnt != '0);
  assign o_rd_data  = mem[rp];
  assign wr = i_wr_valid && o_wr_ready;
  assign rd = o_rd_valid && i_rd_ready;
  always_ff @(posedge i_mclk) begin
    if (wr) begin
      mem[wp] <= i_wr_data;
    end
  end
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end else begin
      if (wr) begin
        wp <= (wp == AW'(DEPTH-1)) ? '0 : wp + 1'b1;
      end
      if (rd) begin
        rp <= (rp == AW'(DEPTH-1)) ? '0 : rp + 1'b1;
      end
      cnt <= cnt + (AW+1)'(wr) - (AW+1)'(rd);
    end
  end
endmodule
`default_nettype wire

// File: logic/fpc_host.sv
`timescale 1ns/100ps
`default_nettype none
module fpc_host
  import fpc_pkg::*;
#(
  parameter int RATIO = FPC_RATIO,
  parameter int WORDS = FPC_WORDS
) (
  // system
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  // link
  fpc_if.host              link,
  // user side
  input  wire logic        i_start,
  input  wire logic        i_word_valid,
  input  wire logic [31:0] i_word,
  output logic             o_word_ready,
  output logic             o_busy,
  output logic             o_done
);
  typedef enum {IDLE, STOP, PULSE, WAIT_ST, FETCH, CLOCK, TAIL} fpc_hstate_t;
  fpc_hstate_t st;
  logic [15:0] cnt;
  logic [7:0]  phase;
  logic [15:0] words;
  logic [1:0]  tails;
  logic        st_s1, st_s2;
  logic        cd_s1, cd_s2;
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      st_s1 <= 1'b0; st_s2 <= 1'b0; cd_s1 <= 1'b0; cd_s2 <= 1'b0;
    end else begin
      st_s1 <= link.status_n; st_s2 <= st_s1;
      cd_s1 <= link.config_complete; cd_s2 <= cd_s1;
    end
  end
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      st <= IDLE; cnt <= '0; phase <= '0; words <= '0; tails <= '0;
      link.cfg_request_n <= 1'b1; link.cfg_data_clock <= 1'b0; link.data <= '0;
      o_word_ready <= 1'b0; o_busy <= 1'b0; o_done <= 1'b0;
    end else begin
      o_word_ready <= 1'b0;
      case (st)
        IDLE: begin
          // after a finished load the clock keeps running, driven
          if (o_done) begin
            cnt <= cnt + 1'b1;
            if (cnt == 16'(FPC_DIV/2 - 1)) begin
              link.cfg_data_clock <= 1'b1;
            end
            if (cnt == 16'(FPC_DIV - 1)) begin
              link.cfg_data_clock <= 1'b0;
              cnt <= '0;
            end
          end
          if (i_start) begin
            st     <= STOP;
            o_busy <= 1'b1;
          end
        end
        // a running clock pulse ends whole before the request falls
        STOP: begin
          if (o_done && (link.cfg_data_clock || (cnt == 16'(FPC_DIV/2 - 1)))) begin
            cnt <= cnt + 1'b1;
            if (cnt == 16'(FPC_DIV/2 - 1)) begin
              link.cfg_data_clock <= 1'b1;
            end
            if (cnt == 16'(FPC_DIV - 1)) begin
              link.cfg_data_clock <= 1'b0;
              cnt <= '0;
            end
          end else begin
            st                  <= PULSE;
            cnt                 <= '0;
            o_done              <= 1'b0;
            link.cfg_request_n  <= 1'b0;
            link.cfg_data_clock <= 1'b0;
          end
        end
        PULSE: begin
          cnt <= cnt + 1'b1;
          if (cnt == 16'(FPC_CFG_LOW_CYC - 1)) begin link.cfg_request_n <= 1'b1; st <= WAIT_ST; end
        end
        WAIT_ST: if (st_s2) begin st <= FETCH; words <= '0; end
        FETCH: if (i_word_valid) begin
          link.data <= i_word; o_word_ready <= 1'b1;
          st <= CLOCK; cnt <= '0; phase <= '0;
        end
        CLOCK: begin
          cnt <= cnt + 1'b1;
          if (cnt == 16'(FPC_DIV/2 - 1)) link.cfg_data_clock <= 1'b1;
          if (cnt == 16'(FPC_DIV - 1)) begin
            link.cfg_data_clock <= 1'b0; cnt <= '0;
            if (phase == 8'(RATIO - 1)) begin
              words <= words + 1'b1;
              st <= (words == 16'(WORDS - 1)) ? TAIL : FETCH;
              tails <= '0;
            end else phase <= phase + 1'b1;
          end
        end
        TAIL: if (cd_s2) begin
          cnt <= cnt + 1'b1;
          if (cnt == 16'(FPC_DIV/2 - 1)) link.cfg_data_clock <= 1'b1;
          if (cnt == 16'(FPC_DIV - 1)) begin
            link.cfg_data_clock <= 1'b0; cnt <= '0; tails <= tails + 1'b1;
            if (tails == 2'd1) begin st <= IDLE; o_busy <= 1'b0; o_done <= 1'b1; end
          end
        end
        default: st <= IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: bench/fpc_link_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module fpc_link_asserts
  import fpc_pkg::*;
(
  input wire logic        i_mclk,
  input wire logic        i_rst_n,
  input wire logic        cfg_request_n,
  input wire logic        status_n,
  input wire logic        config_complete,
  input wire logic        cfg_data_clock,
  input wire logic [31:0] data,
  input wire logic        init_done
);
  logic [7:0] por_cnt;
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      por_cnt <= 8'h00;
    end else if (por_cnt != 8'hff) begin
      por_cnt <= por_cnt + 8'h01;
    end
  end
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);
  property p_por;
    (por_cnt < FPC_POR_CYC - 2) |-> !status_n;
  endproperty
  a_por: assert property (p_por) else $error("status released early");
  property p_req_status;
    $fell(cfg_request_n) |-> ##[1:8] !status_n;
  endproperty
  a_req_status: assert property (p_req_status) else $error("request fall ignored");
  property p_req_done;
    $fell(cfg_request_n) |-> ##[1:8] !config_complete;
  endproperty
  a_req_done: assert property (p_req_done) else $error("complete not cleared");
  property p_status_done;
    !status_n |-> !config_complete;
  endproperty
  a_status_done: assert property (p_status_done) else $error("complete high in clear");
  property p_done_rise;
    $rose(config_complete) |-> status_n && cfg_request_n;
  endproperty
  a_done_rise: assert property (p_done_rise) else $error("complete rose early");
  property p_done_hold;
    config_complete && cfg_request_n |=> config_complete;
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("complete dropped");
  property p_user_lines;
    $rose(init_done) |-> config_complete && status_n && cfg_request_n;
  endproperty
  a_user_lines: assert property (p_user_lines) else $error("user lines not high");
  property p_data_hold;
    cfg_data_clock |-> $stable(data);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data moved");
  property p_clk_shape;
    $rose(cfg_data_clock) |-> cfg_data_clock [*2] ##1 !cfg_data_clock;
  endproperty
  a_clk_shape: assert property (p_clk_shape) else $error("clock shape wrong");
  property p_clk_idle;
    !cfg_request_n |-> !cfg_data_clock;
  endproperty
  a_clk_idle: assert property (p_clk_idle) else $error("clock runs in clear");
  c_done: cover property ($rose(config_complete));
  c_init: cover property ($rose(init_done));
  c_restart: cover property ($fell(cfg_request_n) && config_complete);
endmodule
`default_nettype wire

// File: bench/test_fast_parallel_config_port.sv
`timescale 1ns/100ps
`default_nettype none
module test_fast_parallel_config_port;
  import fpc_pkg::*;
  logic        i_mclk = 1'b0, i_rst_n = 1'b0, i_start = 1'b0, i_word_valid = 1'b0, i_word_ready = 1'b1;
  logic        i_init_done_en = 1'b0, i_osc_tick = 1'b0, i_user_clk_tick = 1'b0, saw = 1'b0, pause = 1'b0;
  logic        o_word_valid, o_word_ready, o_done, o_user_mode, o_busy;
  logic [31:0] i_word = 32'h0000_0000, o_word;
  logic [1:0]  i_init_src = 2'h0;
  logic [7:0]  tx = 8'h00, rx = 8'h00, tick = 8'h00;
  int          bad_count = 0, checked = 0, cyc = 0;
  wire logic [7:0] nt = i_start ? 8'h00 : tx + 8'(o_word_ready);
  fpc_if link ();
  fpc_host #(.RATIO(2), .WORDS(16)) fpc_host_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .link(link),
    .i_start(i_start), .i_word_valid(i_word_valid), .i_word(i_word), .o_word_ready(o_word_ready),
    .o_busy(o_busy), .o_done(o_done));
  fpc_device #(.RATIO(2), .WORDS(16)) fpc_device_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .link(link),
    .o_word_valid(o_word_valid), .o_word(o_word), .i_word_ready(i_word_ready), .i_init_src(i_init_src),
    .i_init_done_en(i_init_done_en), .i_user_clk_tick(i_user_clk_tick), .i_osc_tick(i_osc_tick),
    .o_user_mode(o_user_mode));
  fpc_link_asserts fpc_link_asserts_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .cfg_request_n(link.cfg_request_n),
    .status_n(link.status_n), .config_complete(link.config_complete), .cfg_data_clock(link.cfg_data_clock),
    .data(link.data), .init_done(link.init_done));
  always #10 i_mclk = ~i_mclk;
  // ****
  // helpers
  // ****
  function automatic logic [31:0] pat(logic [7:0] k);
    return {4{k ^ 8'h3c}} ^ 32'h0f0f_0000;
  endfunction
  task automatic chk(string name, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic end_of_test;
    if (bad_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    tick <= tick + 8'h01;
    i_osc_tick <= (tick[1:0] == 2'h3);
    i_user_clk_tick <= tick[0];
    tx <= nt;
    i_word <= pat(nt);
    i_word_valid <= (nt < 8'h10) && !(pause && tick[4]);
    saw <= !i_start && (saw || !link.init_done);
    if (o_word_valid && i_word_ready) begin
      chk("word", pat(rx), o_word);
      rx <= rx + 8'h01;
    end
    if (i_start) begin
      rx <= 8'h00;
    end
    if (cyc == 5000) begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic run_load(logic [1:0] src, logic en, logic stall);
    int n;
    i_init_src <= src;
    i_init_done_en <= en;
    i_word_ready <= !stall;
    pause <= stall;
    @(posedge i_mclk);
    i_start <= 1'b1;
    @(posedge i_mclk);
    i_start <= 1'b0;
    n = 0;
    while (o_word_valid !== 1'b1 && n < 2000) begin
      @(posedge i_mclk);
      n++;
    end
    // with stall set the sink stays off while words pile up in the buffer
    repeat (24) @(posedge i_mclk);
    i_word_ready <= 1'b1;
    while (o_user_mode !== 1'b1 && n < 3000) begin
      @(posedge i_mclk);
      n++;
    end
    chk("user_mode", 32'h0000_0001, 32'(o_user_mode));
    chk("words", 32'h0000_0010, 32'(rx));
    chk("lines", 32'h0000_0007, 32'({link.cfg_request_n, link.status_n, link.config_complete}));
    chk("init_low", 32'(en), 32'(saw));
    chk("done", 32'h0000_0001, 32'(o_done));
    chk("busy", 32'h0000_0000, 32'(o_busy));
    // the host clock now runs freely and must change nothing
    repeat (40) @(posedge i_mclk);
    chk("ignore_clk", 32'h0000_0001, 32'(o_user_mode));
    chk("no_extra", 32'h0000_0010, 32'(rx));
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_first_load;
    run_load(FPC_INIT_OSC, 1'b1, 1'b0);
  endtask
  task automatic t_reload_stalled;
    run_load(FPC_INIT_USER, 1'b0, 1'b1);
  endtask
  task automatic t_cfg_data_clock_init;
    run_load(FPC_INIT_CFG_DATA_CLOCK, 1'b1, 1'b0);
  endtask
  initial begin
    repeat (8) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    t_first_load();
    t_reload_stalled();
    t_cfg_data_clock_init();
    end_of_test();
  end
endmodule
`default_nettype wire
